// ==== spcr_pkg.sv ====
// Package: register map, field layout and timing constants of the poll config block
package spcr_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned NUM_INPUTS = 24;
    localparam int unsigned DATA_W = 24;
    // Printed offsets are register indexes; byte address is four times that
    localparam logic [7:0] MAIN_SETTINGS_IDX = 8'h1A;
    localparam logic [7:0] CHANNEL_ENABLE_IDX = 8'h1B;
    localparam logic [7:0] POLL_STATUS_IDX = 8'h1E;
    localparam logic [31:0] MAIN_SETTINGS_ADDR = {22'h00_0000, MAIN_SETTINGS_IDX, 2'b00};
    localparam logic [31:0] CHANNEL_ENABLE_ADDR = {22'h00_0000, CHANNEL_ENABLE_IDX, 2'b00};
    localparam logic [31:0] POLL_STATUS_ADDR = {22'h00_0000, POLL_STATUS_IDX, 2'b00};
    localparam logic [23:0] MAIN_SETTINGS_RST = 24'h00_0000;
    localparam logic [23:0] CHANNEL_ENABLE_RST = 24'h00_0000;
    localparam int unsigned SWRST_BIT = 0;
    localparam int unsigned POLL_TIME_LSB = 1;
    localparam int unsigned POLL_TIME_MSB = 4;
    localparam int unsigned POLL_EN_BIT = 10;
    localparam int unsigned RUN_BIT = 11;
    localparam logic [3:0] POLL_CODE_MAX = 4'hC;
    localparam logic [3:0] POLL_CODE_DEFAULT = 4'h2;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned INTERVAL_MS [13] = '{2, 4, 8, 16, 32, 48, 64, 128, 256, 512,
                                               1024, 2048, 4096};
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] HSIZE_WORD = 3'b010;
    typedef enum logic [1:0] {SPCR_IDLE, SPCR_CONT, SPCR_WAIT, SPCR_SCAN} spcr_state_t;
endpackage : spcr_pkg

// ==== spcr_cfg_if.sv ====
// Interface: configuration fields passed from register bank to poll sequencer
interface spcr_cfg_if;
    logic run;
    logic poll_en;
    logic [3:0] poll_code;
    logic [spcr_pkg::NUM_INPUTS-1:0] chan_en;
    logic [4:0] chan_idx;
    logic busy;
    modport regs (output run, output poll_en, output poll_code, output chan_en,
                  input chan_idx, input busy);
    modport seq (input run, input poll_en, input poll_code, input chan_en,
                 output chan_idx, output busy);
endinterface : spcr_cfg_if

// ==== spcr_poll_seq.sv ====
// Poll sequencer: interval timer and scan over enabled switch inputs
module spcr_poll_seq #(
    parameter int unsigned MS_CYCLES = spcr_pkg::CYC_PER_MS
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic soft_rst,
    spcr_cfg_if.seq cfg,
    output logic [spcr_pkg::NUM_INPUTS-1:0] sample_strobe,
    output logic wetting_on
);
    spcr_pkg::spcr_state_t state_reg;
    spcr_pkg::spcr_state_t state_next;
    logic [31:0] tick_reg;
    logic [12:0] ms_reg;
    logic [4:0] idx_reg;
    logic [3:0] code_eff;
    logic [12:0] interval_ms;
    logic ms_tick;
    logic period_done;
    logic idx_on;
    logic scan_last;

    // Codes above Ch give 8 ms
    assign code_eff = (cfg.poll_code > spcr_pkg::POLL_CODE_MAX) ?
                      spcr_pkg::POLL_CODE_DEFAULT : cfg.poll_code;
    assign interval_ms = 13'(spcr_pkg::INTERVAL_MS[code_eff]);
    assign ms_tick = (tick_reg == MS_CYCLES - 1);
    assign period_done = ms_tick && (ms_reg == interval_ms - 13'd1);
    assign idx_on = cfg.chan_en[idx_reg];
    assign scan_last = (idx_reg == 5'(spcr_pkg::NUM_INPUTS - 1));
    assign cfg.chan_idx = idx_reg;
    assign cfg.busy = (state_reg == spcr_pkg::SPCR_SCAN);

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            spcr_pkg::SPCR_IDLE:
                if (cfg.run)
                    state_next = cfg.poll_en ? spcr_pkg::SPCR_SCAN : spcr_pkg::SPCR_CONT;
            spcr_pkg::SPCR_CONT:
                if (!cfg.run || cfg.poll_en)
                    state_next = spcr_pkg::SPCR_IDLE;
            spcr_pkg::SPCR_WAIT:
                if (!cfg.run)
                    state_next = spcr_pkg::SPCR_IDLE;
                else if (period_done)
                    state_next = spcr_pkg::SPCR_SCAN;
            spcr_pkg::SPCR_SCAN:
                if (!cfg.run)
                    state_next = spcr_pkg::SPCR_IDLE;
                else if (scan_last)
                    state_next = spcr_pkg::SPCR_WAIT;
            default:
                state_next = spcr_pkg::SPCR_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn || soft_rst)
        begin
            state_reg <= spcr_pkg::SPCR_IDLE;
            tick_reg <= '0;
            ms_reg <= '0;
            idx_reg <= '0;
            sample_strobe <= '0;
            wetting_on <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            tick_reg <= (ms_tick || state_reg != spcr_pkg::SPCR_WAIT) ? '0 : tick_reg + 32'd1;
            if (state_reg != spcr_pkg::SPCR_WAIT || period_done)
                ms_reg <= '0;
            else if (ms_tick)
                ms_reg <= ms_reg + 13'd1;
            idx_reg <= (state_reg == spcr_pkg::SPCR_SCAN && !scan_last) ? idx_reg + 5'd1 : '0;
            sample_strobe <= '0;
            if (state_reg == spcr_pkg::SPCR_SCAN && idx_on)
                sample_strobe[idx_reg] <= 1'b1;
            // Current stays on while the last strobe of a scan is out
            wetting_on <= (state_next == spcr_pkg::SPCR_CONT) ||
                          (state_next == spcr_pkg::SPCR_SCAN) ||
                          (state_reg == spcr_pkg::SPCR_SCAN && idx_on);
        end
    end
endmodule // spcr_poll_seq

// ==== spcr_top.sv ====
// Top: AHB-Lite register bank for poll interval, soft reset and channel enables
//
// Added by the designer: the AHB-Lite register port.
module spcr_top #(
    parameter int unsigned MS_CYCLES = spcr_pkg::CYC_PER_MS
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [spcr_pkg::NUM_INPUTS-1:0] sample_strobe,
    output logic wetting_on
);
    logic [23:0] settings_reg;
    logic [23:0] chan_en_reg;
    logic soft_rst_reg;
    logic wr_pend_reg;
    logic [31:0] addr_reg;
    logic [31:0] rdata_next;
    logic addr_phase;
    logic wr_settings;
    logic wr_chan;
    logic swrst_req;
    spcr_cfg_if cfg_bus ();

    assign addr_phase = hsel && hready && htrans[1];
    assign wr_settings = wr_pend_reg && (addr_reg == spcr_pkg::MAIN_SETTINGS_ADDR);
    assign wr_chan = wr_pend_reg && (addr_reg == spcr_pkg::CHANNEL_ENABLE_ADDR);
    // Only a written 1 triggers reset
    assign swrst_req = wr_settings && hwdata[spcr_pkg::SWRST_BIT];

    // Reset bit never stored, reads 0
    assign rdata_next = (haddr == spcr_pkg::MAIN_SETTINGS_ADDR) ?
                            {8'h00, settings_reg[23:1], 1'b0} :
                        (haddr == spcr_pkg::CHANNEL_ENABLE_ADDR) ? {8'h00, chan_en_reg} :
                        (haddr == spcr_pkg::POLL_STATUS_ADDR) ?
                            {26'h000_0000, cfg_bus.busy, cfg_bus.chan_idx} : 32'h0000_0000;

    assign cfg_bus.run = settings_reg[spcr_pkg::RUN_BIT];
    assign cfg_bus.poll_en = settings_reg[spcr_pkg::POLL_EN_BIT];
    assign cfg_bus.poll_code = settings_reg[spcr_pkg::POLL_TIME_MSB:spcr_pkg::POLL_TIME_LSB];
    assign cfg_bus.chan_en = chan_en_reg;

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            wr_pend_reg <= 1'b0;
            addr_reg <= '0;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            wr_pend_reg <= addr_phase && hwrite;
            if (addr_phase)
                addr_reg <= haddr;
            if (addr_phase && !hwrite)
                hrdata <= rdata_next;
        end
    end

    // Soft reset pulses one cycle; bus keeps working through it
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            soft_rst_reg <= 1'b0;
        else
            soft_rst_reg <= swrst_req;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn || soft_rst_reg || swrst_req)
        begin
            settings_reg <= spcr_pkg::MAIN_SETTINGS_RST;
            chan_en_reg <= spcr_pkg::CHANNEL_ENABLE_RST;
        end
        else
        begin
            if (wr_settings)
                settings_reg <= {hwdata[23:1], 1'b0};
            if (wr_chan)
                chan_en_reg <= hwdata[23:0];
        end
    end

    spcr_poll_seq #(
        .MS_CYCLES(MS_CYCLES)
    ) u_seq (
        .core_clk(core_clk),
        .rstn(rstn),
        .soft_rst(soft_rst_reg),
        .cfg(cfg_bus.seq),
        .sample_strobe(sample_strobe),
        .wetting_on(wetting_on)
    );
endmodule // spcr_top

// ==== spcr_checker.sv ====
// Checker: bus answer and poll output assertions of the poll config block
module spcr_checker (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [spcr_pkg::NUM_INPUTS-1:0] sample_strobe,
    input wire logic wetting_on
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    logic set_wr_q, set_rd_q, unm_rd_q;
    wire logic ap = hsel & hready & htrans[1];
    wire logic at_set = haddr == spcr_pkg::MAIN_SETTINGS_ADDR;
    wire logic mapped = at_set | (haddr == spcr_pkg::CHANNEL_ENABLE_ADDR)
        | (haddr == spcr_pkg::POLL_STATUS_ADDR);
    always_ff @(posedge core_clk)
    begin
        set_wr_q <= rstn & ap & hwrite & at_set;
        set_rd_q <= rstn & ap & !hwrite & at_set;
        unm_rd_q <= rstn & ap & !hwrite & !mapped;
    end
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("error response");
    chk_zero_wait: assert property (hreadyout == 1'b1)
        else $error("wait state");
    chk_upper_zero: assert property (hrdata[31:24] == 8'h00)
        else $error("upper read bits set");
    chk_one_strobe: assert property ($onehot0(sample_strobe))
        else $error("two inputs sampled at once");
    chk_strobe_wet: assert property (|sample_strobe |-> wetting_on)
        else $error("sample without wetting");
    chk_soft_clear: assert property (set_wr_q && hwdata[0]
        |-> ##[1:3] (!wetting_on && sample_strobe == '0))
        else $error("soft reset left block running");
    chk_bit0_zero: assert property (set_rd_q |-> !hrdata[0])
        else $error("reset bit reads one");
    chk_unmapped_zero: assert property (unm_rd_q |-> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule // spcr_checker
bind spcr_top spcr_checker u_spcr_checker (.core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .sample_strobe, .wetting_on);

// ==== spcr_host.sv ====
// Host model: AHB-Lite master issuing single word transfers
module spcr_host (
    input wire logic core_clk,
    input wire logic [31:0] hrdata,
    input wire logic hready,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic hang
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {hsel, haddr, htrans, hwrite, hsize, hwdata, hang} = '0;
    // Bounded: a slave that never answers marks a hang
    task automatic wait_ready();
        int n;
        for (n = 0; n < 16; n++)
        begin
            @(posedge core_clk);
            if (hready === 1'b1)
                break;
        end
        if (n == 16)
            hang = 1'b1;
    endtask
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] rd);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= spcr_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        hsize <= spcr_pkg::HSIZE_WORD;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
        // Stale data would hide a slave sampling late
        hwdata <= ~d;
    endtask
endmodule // spcr_host

// ==== spcr_top_tb.sv ====
// Testbench: register access, scan, interval and soft reset scenarios
module spcr_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MS = 2;
    localparam logic [31:0] A_SET = spcr_pkg::MAIN_SETTINGS_ADDR;
    localparam logic [31:0] A_EN = spcr_pkg::CHANNEL_ENABLE_ADDR;
    localparam logic [31:0] RUN = 32'h0000_0800;
    localparam logic [31:0] POLL = 32'h0000_0400;
    logic core_clk, rstn, hsel, hwrite, hreadyout, hresp, wetting_on, hang;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [23:0] sample_strobe;
    int n_errors = 0;
    int checks_done = 0;
    spcr_top #(.MS_CYCLES(MS)) u_spcr_top (.core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sample_strobe,
        .wetting_on);
    spcr_host u_spcr_host (.core_clk, .hrdata, .hready(hreadyout), .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hang);
    task automatic summarize();
        if (hang === 1'b1)
            n_errors++;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        u_spcr_host.xfer(1'b1, a, d, rdv);
        // A bus hang ends the run at once
        if (hang === 1'b1)
            summarize();
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        u_spcr_host.xfer(1'b0, a, 32'h0000_0000, rdv);
        if (hang === 1'b1)
            summarize();
        check(rdv, exp);
    endtask
    task automatic t_registers();
        rd(A_EN, 32'h0000_0000);
        rd(A_SET, 32'h0000_0000);
        wr(A_EN, 32'hFFA5_5A0F);
        rd(A_EN, 32'h00A5_5A0F);
        wr(A_SET, 32'h0000_0016);
        rd(A_EN, 32'h00A5_5A0F);
        wr(32'h0000_0070, 32'h0000_FFFF);
        rd(32'h0000_0070, 32'h0000_0000);
    endtask
    task automatic t_scan_skip();
        logic [23:0] seen;
        seen = '0;
        wr(A_EN, 32'h0080_0081);
        wr(A_SET, RUN | POLL);
        repeat (200) @(negedge core_clk) seen |= sample_strobe;
        check({8'h00, seen}, 32'h0080_0081);
    endtask
    task automatic period(input logic [3:0] code, output int p);
        int w;
        wr(A_SET, 32'h0000_0000);
        wr(A_SET, RUN | POLL | {27'h0, code, 1'b0});
        for (w = 0; w < 20000 && sample_strobe[0] !== 1'b1; w++) @(negedge core_clk);
        @(negedge core_clk);
        for (p = 1; p < 20000 && sample_strobe[0] !== 1'b1; p++) @(negedge core_clk);
        if (w == 20000 || p == 20000)
        begin
            n_errors++;
            summarize();
        end
    endtask
    task automatic t_intervals();
        int base, p, ms;
        period(4'h0, base);
        for (int c = 1; c < 16; c++)
        begin
            ms = (c > 12) ? 8 : spcr_pkg::INTERVAL_MS[c];
            period(c[3:0], p);
            check(p - base, (ms - 2) * MS);
        end
    endtask
    task automatic t_continuous();
        wr(A_SET, 32'h0000_0000);
        wr(A_SET, RUN);
        repeat (4) @(negedge core_clk);
        check({31'h0, wetting_on}, 32'h0000_0001);
        wr(A_SET, 32'h0000_0000);
        repeat (4) @(negedge core_clk);
        check({31'h0, wetting_on}, 32'h0000_0000);
        // Idle sequencer: not busy, channel index 0
        rd(spcr_pkg::POLL_STATUS_ADDR, 32'h0000_0000);
    endtask
    task automatic t_soft_reset();
        wr(A_EN, 32'h00FF_FFFF);
        wr(A_SET, RUN | POLL | 32'h0000_0018);
        wr(A_SET, RUN | 32'h0000_0001);
        rd(A_SET, 32'h0000_0000);
        rd(A_EN, 32'h0000_0000);
        check({31'h0, wetting_on}, 32'h0000_0000);
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial
    begin
        rstn = 1'b0;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        t_registers();
        t_scan_skip();
        t_intervals();
        t_continuous();
        t_soft_reset();
        summarize();
    end
endmodule // spcr_top_tb
